// File: core/nes_pkg.sv
// Purpose: Shared constants and types for the NAND erase/status/id/reset host controller
// Assumes: 50 MHz system clock, 8-bit NAND command bus
// Notes:   Strobe widths are conservative whole-cycle figures
package nes_pkg;
  // Clock and times
  localparam int CLK_MHZ    = 50;
  localparam int PWRUP_US   = 10;
  localparam int STROBE_NS  = 40;
  localparam int READ_NS    = 120;
  localparam int WB_NS      = 100;
  localparam int PWRUP_CYC  = PWRUP_US * CLK_MHZ;
  localparam int WR_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RD_CYC     = (READ_NS * CLK_MHZ + 999) / 1000;
  localparam int WB_CYC     = (WB_NS * CLK_MHZ + 999) / 1000;

  // Command bytes
  localparam logic [7:0] CMD_ERASE_SETUP   = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_STATUS        = 8'h70;
  localparam logic [7:0] CMD_READ_ID       = 8'h90;
  localparam logic [7:0] CMD_RESET         = 8'hFF;
  localparam logic [7:0] ID_ADDR           = 8'h00;

  // Status register layout and value after reset
  localparam int         ST_FAIL_BIT   = 0;
  localparam int         ST_READY_BIT  = 6;
  localparam int         ST_NOWP_BIT   = 7;
  localparam logic [7:0] STATUS_RESET  = 8'hC0;

  // Erase block address field position
  localparam int BLK_LO_BITS = 3;

  typedef enum logic [1:0] {
    OP_ERASE  = 2'h0,
    OP_STATUS = 2'h1,
    OP_ID     = 2'h2,
    OP_RESET  = 2'h3
  } nes_op_t;

  typedef enum logic [2:0] {
    K_CMD  = 3'h0,
    K_ADDR = 3'h1,
    K_READ = 3'h2,
    K_WAIT = 3'h3,
    K_END  = 3'h4
  } nes_kind_t;

  typedef struct packed {
    nes_kind_t  kind;
    logic [7:0] data;
  } nes_item_t;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic       io_oe;
    logic [7:0] io_out;
  } nes_pins_t;
endpackage

// File: core/nes_host.sv
// Purpose: Host-side sequencer that erases blocks, reads status and id, and resets a NAND device
// Assumes: Device pins are asynchronous to CLOCK; user port is synchronous to CLOCK
// Notes:   One operation at a time; status and id bytes come back on RESULT
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Erase sends setup 60h then exactly two block address cycles.
// - Confirm D0h only follows setup and both address cycles.
// - Status mode lasts until a new command; every operation starts with one.
// - Id read is 90h, address 00h, then maker and device bytes.
// - Hold write protect low during power-up and wait 10 us before commands.
// - While busy only status read and reset commands may be written.
module nes_host (
  // Clock and reset
  input  wire logic          CLOCK,
  input  wire logic          SYS_RST,
  // User request
  input  wire logic          CMD_VALID,
  input  wire nes_pkg::nes_op_t CMD_OP,
  input  wire logic [9:0]    CMD_BLOCK,
  input  wire logic          WP_HOLD,
  output logic               CMD_READY,
  // User answer
  output logic               RESULT_VALID,
  output logic [15:0]        RESULT,
  // NAND pins
  output logic               NAND_CLE,
  output logic               NAND_ALE,
  output logic               NAND_CE_N,
  output logic               NAND_WE_N,
  output logic               NAND_RE_N,
  output logic               NAND_WP_N,
  output logic               NAND_IO_OE,
  output logic [7:0]         NAND_IO_OUT,
  input  wire logic [7:0]    NAND_IO_IN,
  input  wire logic          NAND_RB_N
);

  typedef enum logic [3:0] {
    ST_PWRUP   = 4'h0,
    ST_IDLE    = 4'h1,
    ST_FETCH   = 4'h2,
    ST_WR_LOW  = 4'h3,
    ST_WR_HIGH = 4'h4,
    ST_RD_LOW  = 4'h5,
    ST_RD_HIGH = 4'h6,
    ST_WB      = 4'h7,
    ST_RB      = 4'h8
  } nes_state_t;

  localparam logic [8:0] PWRUP_LAST = 9'(nes_pkg::PWRUP_CYC - 1);
  localparam logic [8:0] WR_LAST    = 9'(nes_pkg::WR_CYC - 1);
  localparam logic [8:0] RD_LAST    = 9'(nes_pkg::RD_CYC - 1);
  localparam logic [8:0] WB_LAST    = 9'(nes_pkg::WB_CYC - 1);

  nes_state_t        state_q, state_d;
  nes_pkg::nes_pins_t pins_q, pins_d;
  nes_pkg::nes_op_t  op_q, op_d;
  nes_pkg::nes_item_t item;
  logic [9:0]        blk_q, blk_d;
  logic [3:0]        step_q, step_d;
  logic [8:0]        cnt_q, cnt_d;
  logic [15:0]       res_q, res_d;
  logic              ready_q, ready_d;
  logic              valid_q, valid_d;
  logic [2:0]        rb_s;
  logic              rb_q;
  logic [7:0]        io_s1, io_s2, io_s3;

  // Operation scripts; erase ends with a status read so the caller sees pass or fail
  function automatic nes_pkg::nes_item_t seq_item(input nes_pkg::nes_op_t op, input logic [3:0] step,
                                                  input logic [9:0] blk);
    nes_pkg::nes_item_t it;
    it = '{kind: nes_pkg::K_END, data: 8'h00};
    unique case (op)
      nes_pkg::OP_ERASE: begin
        unique case (step)
          4'h0:    it = '{kind: nes_pkg::K_CMD,  data: nes_pkg::CMD_ERASE_SETUP};
          4'h1:    it = '{kind: nes_pkg::K_ADDR,
                          data: {blk[nes_pkg::BLK_LO_BITS-1:0], 5'h00}};
          4'h2:    it = '{kind: nes_pkg::K_ADDR,
                          data: {1'b0, blk[9:nes_pkg::BLK_LO_BITS]}};
          4'h3:    it = '{kind: nes_pkg::K_CMD,  data: nes_pkg::CMD_ERASE_CONFIRM};
          4'h4:    it = '{kind: nes_pkg::K_WAIT, data: 8'h00};
          4'h5:    it = '{kind: nes_pkg::K_CMD,  data: nes_pkg::CMD_STATUS};
          4'h6:    it = '{kind: nes_pkg::K_READ, data: 8'h00};
          default: it = '{kind: nes_pkg::K_END,  data: 8'h00};
        endcase
      end
      nes_pkg::OP_STATUS: begin
        unique case (step)
          4'h0:    it = '{kind: nes_pkg::K_CMD,  data: nes_pkg::CMD_STATUS};
          4'h1:    it = '{kind: nes_pkg::K_READ, data: 8'h00};
          default: it = '{kind: nes_pkg::K_END,  data: 8'h00};
        endcase
      end
      nes_pkg::OP_ID: begin
        unique case (step)
          4'h0:    it = '{kind: nes_pkg::K_CMD,  data: nes_pkg::CMD_READ_ID};
          4'h1:    it = '{kind: nes_pkg::K_ADDR, data: nes_pkg::ID_ADDR};
          4'h2:    it = '{kind: nes_pkg::K_READ, data: 8'h00};
          4'h3:    it = '{kind: nes_pkg::K_READ, data: 8'h00};
          default: it = '{kind: nes_pkg::K_END,  data: 8'h00};
        endcase
      end
      nes_pkg::OP_RESET: begin
        unique case (step)
          4'h0:    it = '{kind: nes_pkg::K_CMD,  data: nes_pkg::CMD_RESET};
          4'h1:    it = '{kind: nes_pkg::K_WAIT, data: 8'h00};
          default: it = '{kind: nes_pkg::K_END,  data: 8'h00};
        endcase
      end
    endcase
    return it;
  endfunction

  // Pin synchronisers; ready/busy is open drain so it is only ever sampled here
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rb_s  <= 3'h0;
      rb_q  <= 1'b0;
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      io_s3 <= 8'h00;
    end else begin
      rb_s  <= {rb_s[1:0], NAND_RB_N};
      if (rb_s[1] == rb_s[2]) begin
        rb_q <= rb_s[2];
      end
      io_s1 <= NAND_IO_IN;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
    end
  end

  assign item = seq_item(op_q, step_q, blk_q);

  // Sequencer next state
  always_comb begin
    state_d = state_q;
    pins_d  = pins_q;
    op_d    = op_q;
    blk_d   = blk_q;
    step_d  = step_q;
    cnt_d   = cnt_q + 9'h001;
    res_d   = res_q;
    ready_d = ready_q;
    valid_d = 1'b0;
    unique case (state_q)
      ST_PWRUP: begin
        pins_d.wp_n = 1'b0;
        if (cnt_q == PWRUP_LAST) begin
          state_d = ST_IDLE;
          ready_d = 1'b1;
        end
      end
      ST_IDLE: begin
        pins_d.wp_n = ~WP_HOLD;
        if (CMD_VALID && ready_q) begin
          op_d        = CMD_OP;
          blk_d       = CMD_BLOCK;
          step_d      = 4'h0;
          res_d       = 16'h0000;
          ready_d     = 1'b0;
          pins_d.ce_n = 1'b0;
          state_d     = ST_FETCH;
        end
      end
      ST_FETCH: begin
        cnt_d = 9'h000;
        unique case (item.kind)
          nes_pkg::K_CMD, nes_pkg::K_ADDR: begin
            pins_d.cle    = (item.kind == nes_pkg::K_CMD);
            pins_d.ale    = (item.kind == nes_pkg::K_ADDR);
            pins_d.io_out = item.data;
            pins_d.io_oe  = 1'b1;
            pins_d.we_n   = 1'b0;
            state_d       = ST_WR_LOW;
          end
          nes_pkg::K_READ: begin
            pins_d.io_oe = 1'b0;
            pins_d.re_n  = 1'b0;
            state_d      = ST_RD_LOW;
          end
          nes_pkg::K_WAIT: begin
            state_d = ST_WB;
          end
          default: begin
            pins_d.ce_n = 1'b1;
            valid_d     = 1'b1;
            ready_d     = 1'b1;
            state_d     = ST_IDLE;
          end
        endcase
      end
      ST_WR_LOW: begin
        if (cnt_q == WR_LAST) begin
          pins_d.we_n = 1'b1;
          cnt_d       = 9'h000;
          state_d     = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH, ST_RD_HIGH: begin
        // Latch controls and data held through the high phase for hold time
        if (cnt_q == WR_LAST) begin
          pins_d.cle   = 1'b0;
          pins_d.ale   = 1'b0;
          pins_d.io_oe = 1'b0;
          step_d       = step_q + 4'h1;
          state_d      = ST_FETCH;
        end
      end
      ST_RD_LOW: begin
        // Sampled late in the strobe so the three-stage data path has settled
        if (cnt_q == RD_LAST) begin
          res_d       = {res_q[7:0], io_s3};
          pins_d.re_n = 1'b1;
          cnt_d       = 9'h000;
          state_d     = ST_RD_HIGH;
        end
      end
      ST_WB: begin
        // Busy may take a while to fall; waiting avoids reading a stale ready
        if (cnt_q == WB_LAST) begin
          state_d = ST_RB;
        end
      end
      ST_RB: begin
        if (rb_q) begin
          step_d  = step_q + 4'h1;
          state_d = ST_FETCH;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= ST_PWRUP;
      pins_q  <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1, re_n: 1'b1,
                   wp_n: 1'b0, io_oe: 1'b0, io_out: 8'h00};
      op_q    <= nes_pkg::OP_STATUS;
      blk_q   <= 10'h000;
      step_q  <= 4'h0;
      cnt_q   <= 9'h000;
      res_q   <= 16'h0000;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pins_q  <= pins_d;
      op_q    <= op_d;
      blk_q   <= blk_d;
      step_q  <= step_d;
      cnt_q   <= cnt_d;
      res_q   <= res_d;
      ready_q <= ready_d;
      valid_q <= valid_d;
    end
  end

  // Outputs straight from registers
  assign CMD_READY    = ready_q;
  assign RESULT_VALID = valid_q;
  assign RESULT       = res_q;
  assign NAND_CLE     = pins_q.cle;
  assign NAND_ALE     = pins_q.ale;
  assign NAND_CE_N    = pins_q.ce_n;
  assign NAND_WE_N    = pins_q.we_n;
  assign NAND_RE_N    = pins_q.re_n;
  assign NAND_WP_N    = pins_q.wp_n;
  assign NAND_IO_OE   = pins_q.io_oe;
  assign NAND_IO_OUT  = pins_q.io_out;

  // Checking helpers: last latched command, address count, time since reset
  logic       latch_q;
  logic [7:0] last_cmd_q;
  logic [2:0] addr_cnt_q;
  logic [9:0] since_rst_q;
  assign latch_q = ~pins_q.we_n & pins_d.we_n;
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      last_cmd_q  <= 8'h00;
      addr_cnt_q  <= 3'h0;
      since_rst_q <= 10'h000;
    end else begin
      if (since_rst_q != 10'h3FF) begin
        since_rst_q <= since_rst_q + 10'h001;
      end
      if (latch_q && pins_q.cle) begin
        last_cmd_q <= pins_q.io_out;
        addr_cnt_q <= 3'h0;
      end else if (latch_q && pins_q.ale) begin
        addr_cnt_q <= addr_cnt_q + 3'h1;
      end
    end
  end

  chk_wp_powerup: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (state_q == ST_PWRUP) |-> !NAND_WP_N) else $error("write protect released during power-up");
  chk_pwrup_wait: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !NAND_WE_N |-> (since_rst_q > 10'(nes_pkg::PWRUP_CYC))) else $error("command before power-up wait");
  chk_latch_excl: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !(NAND_CLE && NAND_ALE)) else $error("command and address latch both high");
  chk_we_width: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $fell(NAND_WE_N) |-> !NAND_WE_N [*2] ##1 NAND_WE_N) else $error("write strobe width wrong");
  chk_erase_pair: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (latch_q && pins_q.cle && pins_q.io_out == nes_pkg::CMD_ERASE_CONFIRM)
    |-> (last_cmd_q == nes_pkg::CMD_ERASE_SETUP && addr_cnt_q == 3'h2)) else $error("confirm out of order");
  chk_erase_addr: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (latch_q && pins_q.ale && last_cmd_q == nes_pkg::CMD_ERASE_SETUP)
    |-> (addr_cnt_q < 3'h2 && (addr_cnt_q != 3'h0 || pins_q.io_out[4:0] == 5'h00)))
    else $error("bad erase address cycle");
  chk_id_addr: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (latch_q && pins_q.ale && last_cmd_q == nes_pkg::CMD_READ_ID)
    |-> (addr_cnt_q == 3'h0 && pins_q.io_out == nes_pkg::ID_ADDR)) else $error("bad id address");
  chk_busy_cmds: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    (!rb_q && $fell(NAND_WE_N) && NAND_CLE)
    |-> (NAND_IO_OUT == nes_pkg::CMD_STATUS || NAND_IO_OUT == nes_pkg::CMD_RESET))
    else $error("command written while busy");
  chk_result_ready: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    RESULT_VALID |-> (CMD_READY && NAND_CE_N) ##1 !RESULT_VALID) else $error("result pulse malformed");

endmodule

`default_nettype wire

// File: tb/nes_nand_model.sv
// Purpose: Behavioural NAND device for the erase/status/id/reset host
// Assumes: Edge driven by strobes, no clock; busy times in ns
// Notes:   A released data bus shows the inverse of the last byte read
`timescale 1ns/1ps
`default_nettype none
module nes_nand_model #(
  parameter logic [7:0] MAKER   = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] DEVICE  = 8'hA5, // Arbitrary identity value
  parameter int         BUSY_NS = 2000
) (
  // Device pins
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       ce_n,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_in,
  output logic [7:0]      io_out,
  output logic            rb_oe,
  // Scenario control and observation
  input  wire logic       fail_en,
  output var logic [9:0]  last_blk,
  output var int          n_erase,
  output var int          n_reset,
  output var int          n_bad
);
  logic [7:0] cmd_q, a0_q, last_q, val;
  logic       fail_q, busy_q, rst_q;
  int         acnt, idn;

  // Power-up state: main_area_read_mode, status clear
  initial begin
    {cmd_q, a0_q, last_q, fail_q, busy_q, rst_q} = '0;
    {acnt, idn, n_erase, n_reset, n_bad} = '0;
    last_blk = 10'h000;
  end

  // Internal operation time; open drain, so only the low level is driven
  task automatic run_busy();
    busy_q = 1'b1;
    #(BUSY_NS);
    busy_q = 1'b0;
  endtask
  assign rb_oe = busy_q;

  // Commands and addresses latch on the write strobe rise
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      if (busy_q && io_in != 8'h70 && io_in != 8'hFF) n_bad++;
      if (io_in == 8'hFF) begin
        if (!rst_q) begin
          rst_q = 1'b1;
          fail_q = 1'b0;
          n_reset++;
          fork run_busy(); join_none
        end
      end else begin
        rst_q = 1'b0;
        if (io_in == 8'hD0 && cmd_q == 8'h60 && acnt == 2) begin
          fail_q = fail_en;
          n_erase++;
          fork run_busy(); join_none
        end
      end
      cmd_q = io_in;
      acnt = 0;
      idn = 0;
    end else if (!ce_n && ale) begin
      if (acnt == 0) a0_q = io_in;
      if (acnt == 1 && cmd_q == 8'h60) last_blk = {io_in[6:0], a0_q[7:5]};
      acnt++;
    end
  end

  // Status is live while output is enabled, so no re-toggle is needed
  always @* begin
    if (cmd_q == 8'h70) val = {wp_n, ~busy_q, 5'h00, fail_q};
    else if (cmd_q == 8'h90) val = (idn == 0) ? MAKER : DEVICE;
    else val = 8'h00;
  end
  always @(posedge re_n) begin
    if (!ce_n) begin
      last_q = val;
      if (cmd_q == 8'h90) idn++;
    end
  end
  assign io_out = (!ce_n && !re_n) ? val : ~last_q;
endmodule
`default_nettype wire

// File: tb/test_nes_host.sv
// Purpose: Self-checking bench for the NAND host sequencer
// Assumes: Behavioural device model on the far side, pull-up on ready/busy
// Notes:   Random block numbers and failures come from a fixed-seed LFSR
`timescale 1ns/1ps
`default_nettype none
module test_nes_host;
  logic CLOCK, SYS_RST, CMD_VALID, WP_HOLD, CMD_READY, RESULT_VALID, fail_en;
  nes_pkg::nes_op_t CMD_OP;
  logic [9:0] CMD_BLOCK, last_blk, blk;
  logic [15:0] RESULT, res;
  logic NAND_CLE, NAND_ALE, NAND_CE_N, NAND_WE_N, NAND_RE_N, NAND_WP_N, NAND_IO_OE, rb_oe;
  logic [7:0] NAND_IO_OUT, dev_out;
  wire logic [7:0] bus = NAND_IO_OE ? NAND_IO_OUT : dev_out;
  wire logic rb_n = rb_oe ? 1'b0 : 1'b1; // Pull-up resolution
  int err_count, n_compared, n_erase, n_reset, n_bad, n;
  logic [31:0] seed;

  nes_host DUT (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
    .CMD_BLOCK(CMD_BLOCK), .WP_HOLD(WP_HOLD), .CMD_READY(CMD_READY), .RESULT_VALID(RESULT_VALID),
    .RESULT(RESULT), .NAND_CLE(NAND_CLE), .NAND_ALE(NAND_ALE), .NAND_CE_N(NAND_CE_N),
    .NAND_WE_N(NAND_WE_N), .NAND_RE_N(NAND_RE_N), .NAND_WP_N(NAND_WP_N), .NAND_IO_OE(NAND_IO_OE),
    .NAND_IO_OUT(NAND_IO_OUT), .NAND_IO_IN(bus), .NAND_RB_N(rb_n));
  nes_nand_model dev (.cle(NAND_CLE), .ale(NAND_ALE), .ce_n(NAND_CE_N), .we_n(NAND_WE_N),
    .re_n(NAND_RE_N), .wp_n(NAND_WP_N), .io_in(bus), .io_out(dev_out), .rb_oe(rb_oe),
    .fail_en(fail_en), .last_blk(last_blk), .n_erase(n_erase), .n_reset(n_reset), .n_bad(n_bad));

  // 50 MHz clock
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // Status byte an idle device should return for the given write protect and fail bits
  function automatic logic [7:0] exp_status(input logic wp_hi, input logic fail);
    return {wp_hi, 1'b1, 5'h00, fail};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One request on the user port, waiting for its result pulse
  task automatic do_op(input nes_pkg::nes_op_t op, input logic [9:0] blk, output logic [15:0] r);
    int k;
    k = 0;
    while (CMD_READY !== 1'b1 && k < 5000) begin
      @(posedge CLOCK);
      #1 k++;
    end
    @(posedge CLOCK);
    CMD_OP <= op;
    CMD_BLOCK <= blk;
    CMD_VALID <= 1'b1;
    @(posedge CLOCK);
    CMD_VALID <= 1'b0;
    k = 0;
    do begin
      @(posedge CLOCK);
      #1 k++;
    end while (RESULT_VALID !== 1'b1 && k < 5000);
    if (k >= 5000) err_count++;
    r = RESULT;
  endtask

  task automatic close_out();
    $display("compares %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog: the run needs a few thousand cycles, so 20000 cycles means a hang
  initial begin
    #400000;
    err_count++;
    close_out();
  end

  initial begin
    {err_count, n_compared} = '0;
    {CMD_VALID, WP_HOLD, fail_en} = '0;
    CMD_OP = nes_pkg::OP_STATUS;
    CMD_BLOCK = 10'h000;
    seed = 32'h0000B73F;
    SYS_RST = 1'b1;
    repeat (8) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    // Power-up wait with write protect held low
    n = 0;
    while (CMD_READY !== 1'b1 && n < 600) begin
      @(posedge CLOCK);
      #1 n++;
      if (n == 2) check(16'(NAND_WP_N), 16'h0000);
    end
    check(16'(n), 16'(nes_pkg::PWRUP_CYC));
    do_op(nes_pkg::OP_STATUS, 10'h000, res);
    check(res, {8'h00, exp_status(1'b1, 1'b0)});
    do_op(nes_pkg::OP_ID, 10'h000, res);
    check(res, {8'h5A, 8'hA5});
    // Erase at the corner blocks, then random blocks and outcomes
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      fail_en = seed[12];
      blk = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : seed[9:0];
      n = n_erase;
      do_op(nes_pkg::OP_ERASE, blk, res);
      check({6'h00, last_blk}, {6'h00, blk});
      check(16'(n_erase - n), 16'h0001);
      check(res, {8'h00, exp_status(1'b1, fail_en)});
    end
    // A failed erase, then two resets: the second is ignored
    fail_en = 1'b1;
    do_op(nes_pkg::OP_ERASE, 10'h155, res);
    check(res, {8'h00, exp_status(1'b1, 1'b1)});
    n = n_reset;
    do_op(nes_pkg::OP_RESET, 10'h000, res);
    check(res, 16'h0000);
    do_op(nes_pkg::OP_RESET, 10'h000, res);
    check(16'(n_reset - n), 16'h0001);
    do_op(nes_pkg::OP_STATUS, 10'h000, res);
    check(res, 16'h00C0);
    // Write protect asserted shows as protected in status
    WP_HOLD <= 1'b1;
    do_op(nes_pkg::OP_STATUS, 10'h000, res);
    check(res, {8'h00, exp_status(1'b0, 1'b0)});
    check(16'(n_bad), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
